// file: verilog/ltil_cfg.svh
`ifndef LTIL_CFG_SVH
`define LTIL_CFG_SVH
// What this block does
// - Transparent: high run sets int, high flag
// - Transparent: low run clears int, sets low
// - Transparent: config access leaves int, flags
// - Transparent: alert response is ignored
// - Every conversion sets conversion ready
// - Shutdown config write changes no flag
// - Running-mode config write clears conversion ready
// - Low limit top bits 11b select EOC
// - EOC: each conversion asserts int, ready
// - EOC: read, run write deassert int; alert only when latched
// - EOC latched: faults set their own flag
// - Config bit 4 selects latched mode
// - Polarity bit maps int state to pin
// - Config read clears conversion ready

// Register byte offsets
`define LTIL_OFS_CFG   5'h00
`define LTIL_OFS_LOW   5'h04
`define LTIL_OFS_HIGH  5'h08
`define LTIL_OFS_STS   5'h0c
`define LTIL_OFS_MASK  5'h10
`define LTIL_OFS_RES   5'h14

// Configuration fields
`define LTIL_F_FC      1:0
`define LTIL_B_POL     3
`define LTIL_B_LATCH   4
`define LTIL_B_FL      5
`define LTIL_B_FH      6
`define LTIL_B_CRDY    7
`define LTIL_F_MODE    10:9
`define LTIL_CFG_RW    16'h061f
`define LTIL_MODE_SHDN 2'h0

// Low limit exponent top bits
`define LTIL_F_LEXP    15:14
`define LTIL_EOC_CODE  2'h3

// Reset values
`define LTIL_RST_CFG   16'h0010
`define LTIL_RST_LOW   16'h0000
`define LTIL_RST_HIGH  16'hbfff

// Status and mask bits
`define LTIL_STS_W     3
`define LTIL_STS_CONV  0
`define LTIL_STS_HI    1
`define LTIL_STS_LO    2

// Fault run lengths per fault count code
`define LTIL_CNT_W     4
`define LTIL_CNT_MAX   4'hf
`define LTIL_FC_N0     4'h1
`define LTIL_FC_N1     4'h2
`define LTIL_FC_N2     4'h4
`define LTIL_FC_N3     4'h8
`endif

// file: verilog/ltil_pkg.sv
package ltil_pkg;
  // Interrupt reporting mode, {eoc, latch}
  typedef enum logic [1:0] {
    mode_transp = 2'b00,
    mode_latch  = 2'b01,
    mode_eoc_t  = 2'b10,
    mode_eoc_l  = 2'b11
  } ltil_mode_e;
  typedef logic [15:0] ltil_word_t;
endpackage

// file: verilog/ltil_conv_if.sv
interface ltil_conv_if;
  logic                evt;     // One-cycle conversion done
  ltil_pkg::ltil_word_t result; // Measurement of that conversion
  modport src (output evt, output result);
  modport snk (input evt, input result);
endinterface

// file: verilog/ltil_link_sampler.sv
`include "ltil_cfg.svh"
module ltil_link_sampler (
  input  wire logic           clk_sys,     // System clock
  input  wire logic           rstn,        // Async reset, active low
  input  wire logic           link_clk,    // Conversion link clock pin
  input  wire logic           link_done,   // Conversion done qualifier pin
  input  wire logic [15:0]    link_result, // Measurement pins
  ltil_conv_if.src            conv         // Conversion events out
);
  logic        clk_s1, clk_s2, clk_s3;
  logic        done_s1, done_s2;
  logic [15:0] res_s1, res_s2;
  logic        evt_r;
  logic [15:0] result_r;
  wire         clk_rise;

  // Two-stage synchronisers, edge history on the second stage only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {clk_s1, clk_s2, clk_s3} <= 3'h0;
      {done_s1, done_s2} <= 2'h0;
      res_s1 <= 16'h0000;
      res_s2 <= 16'h0000;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {link_clk, clk_s1, clk_s2};
      {done_s1, done_s2} <= {link_done, done_s1};
      res_s1 <= link_result;
      res_s2 <= res_s1;
    end
  end

  // A conversion completes on a link clock rise with done high
  assign clk_rise = clk_s2 && !clk_s3;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_r    <= 1'b0;
      result_r <= 16'h0000;
    end else begin
      evt_r    <= clk_rise && done_s2;
      result_r <= (clk_rise && done_s2) ? res_s2 : result_r;
    end
  end

  assign conv.evt    = evt_r;
  assign conv.result = result_r;
endmodule

// file: verilog/ltil_fault_counter.sv
`include "ltil_cfg.svh"
module ltil_fault_counter (
  input  wire logic                  clk_sys, // System clock
  input  wire logic                  rstn,    // Async reset, active low
  input  wire logic                  evt,     // Conversion done
  input  wire logic                  hit,     // Comparison met this conversion
  input  wire logic [`LTIL_CNT_W-1:0] need,   // Run length required
  output logic                       met      // Run criterion met, one cycle
);
  logic [`LTIL_CNT_W-1:0] cnt_r;
  wire  [`LTIL_CNT_W-1:0] cnt_inc;

  // Saturating run length including this conversion
  assign cnt_inc = (cnt_r == `LTIL_CNT_MAX) ? cnt_r : cnt_r + 4'h1;
  assign met     = evt && hit && (cnt_inc >= need);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 4'h0;
    end else if (evt) begin
      cnt_r <= hit ? cnt_inc : 4'h0;
    end
  end

  property p_run_restart;
    @(posedge clk_sys) disable iff (!rstn)
    evt && !hit |=> cnt_r == 4'h0 && !met;
  endproperty
  a_run_restart: assert property (p_run_restart) else $error("run not restarted");
endmodule

// file: verilog/ltil_top.sv
`include "ltil_cfg.svh"
module ltil_top (
  input  wire logic        clk_sys,         // 25 MHz system clock
  input  wire logic        rstn,            // Async reset, active low
  input  wire logic [4:0]  avs_address,     // Register byte address
  input  wire logic        avs_read,        // Read request
  input  wire logic        avs_write,       // Write request
  input  wire logic [31:0] avs_writedata,   // Write data
  input  wire logic [3:0]  avs_byteenable,  // Write byte lanes
  output logic      [31:0] avs_readdata,    // Read data
  output logic             avs_waitrequest, // Low for the answer cycle
  input  wire logic        link_clk,        // Conversion link clock pin
  input  wire logic        link_done,       // Conversion done qualifier pin
  input  wire logic [15:0] link_result,     // Measurement pins
  input  wire logic        alert_resp,      // Alert response pulse, same clock
  output logic             int_pin,         // Interrupt pin level
  output logic             irq              // Level interrupt to software
);
  ltil_conv_if conv ();

  logic [15:0]             cfg_r, low_r, high_r, res_r;
  logic                    fh_r, fl_r, crdy_r, int_st_r;
  logic                    fh_nxt, fl_nxt, crdy_nxt, int_nxt;
  logic [`LTIL_STS_W-1:0]  sts_r, mask_r;
  logic                    wreq_r, irq_r, pin_r;
  logic [31:0]             rdata_r, rd_mux;
  wire                     acc, sel_cfg, sel_low, sel_high, sel_sts, sel_mask, sel_res;
  wire                     rd_cfg, wr_cfg, wr_run, latch_fall, eoc, hi_met, lo_met;
  wire  [15:0]             cfg_wval, cfg_nxt, low_nxt, high_nxt;
  wire  [`LTIL_STS_W-1:0]  sts_nxt, mask_nxt;
  wire  [`LTIL_CNT_W-1:0]  need;
  ltil_pkg::ltil_mode_e    mode;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Consecutive conversions needed per fault count code
  function automatic logic [`LTIL_CNT_W-1:0] fc_need(input logic [1:0] fc);
    case (fc)
      2'h0:    fc_need = `LTIL_FC_N0;
      2'h1:    fc_need = `LTIL_FC_N1;
      2'h2:    fc_need = `LTIL_FC_N2;
      default: fc_need = `LTIL_FC_N3;
    endcase
  endfunction

  ltil_link_sampler u_sampler (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .link_clk    (link_clk),
    .link_done   (link_done),
    .link_result (link_result),
    .conv        (conv.src)
  );

  // Address decode; an access is taken while waitrequest is still high
  assign acc      = (avs_read || avs_write) && wreq_r;
  assign sel_cfg  = avs_address == `LTIL_OFS_CFG;
  assign sel_low  = avs_address == `LTIL_OFS_LOW;
  assign sel_high = avs_address == `LTIL_OFS_HIGH;
  assign sel_sts  = avs_address == `LTIL_OFS_STS;
  assign sel_mask = avs_address == `LTIL_OFS_MASK;
  assign sel_res  = avs_address == `LTIL_OFS_RES;
  assign rd_cfg   = acc && avs_read && sel_cfg;
  assign wr_cfg   = acc && avs_write && sel_cfg;

  // Register write values
  assign cfg_wval = merge16(cfg_r, avs_writedata[15:0], avs_byteenable[1:0]) & `LTIL_CFG_RW;
  assign cfg_nxt  = wr_cfg ? cfg_wval : cfg_r;
  assign low_nxt  = (acc && avs_write && sel_low) ?
                    merge16(low_r, avs_writedata[15:0], avs_byteenable[1:0]) : low_r;
  assign high_nxt = (acc && avs_write && sel_high) ?
                    merge16(high_r, avs_writedata[15:0], avs_byteenable[1:0]) : high_r;
  assign mask_nxt = (acc && avs_write && sel_mask && avs_byteenable[0]) ?
                    avs_writedata[`LTIL_STS_W-1:0] : mask_r;
  assign wr_run     = wr_cfg && (cfg_wval[`LTIL_F_MODE] != `LTIL_MODE_SHDN);
  assign latch_fall = wr_cfg && cfg_r[`LTIL_B_LATCH] && !cfg_wval[`LTIL_B_LATCH];

  assign eoc  = low_r[`LTIL_F_LEXP] == `LTIL_EOC_CODE;
  assign mode = ltil_pkg::ltil_mode_e'({eoc, cfg_r[`LTIL_B_LATCH]});
  assign need = fc_need(cfg_r[`LTIL_F_FC]);

  ltil_fault_counter u_hi_cnt (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .evt     (conv.evt),
    .hit     (conv.result > high_r),
    .need    (need),
    .met     (hi_met)
  );
  ltil_fault_counter u_lo_cnt (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .evt     (conv.evt),
    .hit     (conv.result < low_r),
    .need    (need),
    .met     (lo_met)
  );

  // Flag and interrupt state: clears first, then conversion sets win
  always_comb begin
    fh_nxt   = fh_r;
    fl_nxt   = fl_r;
    int_nxt  = int_st_r;
    crdy_nxt = crdy_r;
    if (rd_cfg || wr_run) begin
      crdy_nxt = 1'b0;
    end
    if (latch_fall) begin
      int_nxt = 1'b0;
    end
    case (mode)
      ltil_pkg::mode_latch: begin
        if (rd_cfg) begin
          {fh_nxt, fl_nxt, int_nxt} = 3'h0;
        end
        if (alert_resp) begin
          int_nxt = 1'b0;
        end
      end
      ltil_pkg::mode_eoc_l: begin
        if (rd_cfg) begin
          {fh_nxt, fl_nxt, int_nxt} = 3'h0;
        end
        if (wr_run || alert_resp) begin
          int_nxt = 1'b0;
        end
      end
      ltil_pkg::mode_eoc_t: begin
        if (rd_cfg || wr_run) begin
          int_nxt = 1'b0;
        end
      end
      default: begin
      end
    endcase
    if (conv.evt) begin
      crdy_nxt = 1'b1;
      case (mode)
        ltil_pkg::mode_transp: begin
          if (hi_met) begin
            {int_nxt, fh_nxt, fl_nxt} = 3'b110;
          end else if (lo_met) begin
            {int_nxt, fh_nxt, fl_nxt} = 3'b001;
          end
        end
        ltil_pkg::mode_latch: begin
          if (hi_met || lo_met) begin
            int_nxt = 1'b1;
          end
          // Build on the cleared value so a same-cycle read still clears
          fh_nxt = fh_nxt || hi_met;
          fl_nxt = fl_nxt || lo_met;
        end
        ltil_pkg::mode_eoc_t: begin
          int_nxt = 1'b1;
          if (hi_met) begin
            {fh_nxt, fl_nxt} = 2'b10;
          end else if (lo_met) begin
            {fh_nxt, fl_nxt} = 2'b01;
          end
        end
        default: begin
          int_nxt = 1'b1;
          fh_nxt  = fh_nxt || hi_met; // Same-cycle read clear is kept
          fl_nxt  = fl_nxt || lo_met;
        end
      endcase
    end
  end

  // Sticky status, cleared by its read; a same-cycle event wins
  assign sts_nxt = ((acc && avs_read && sel_sts) ? {`LTIL_STS_W{1'b0}} : sts_r) |
                   {lo_met, hi_met, conv.evt};

  // Read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_cfg) begin
      rd_mux[15:0] = cfg_r;
      rd_mux[`LTIL_B_FL]   = fl_r;
      rd_mux[`LTIL_B_FH]   = fh_r;
      rd_mux[`LTIL_B_CRDY] = crdy_r;
    end else if (sel_low) begin
      rd_mux[15:0] = low_r;
    end else if (sel_high) begin
      rd_mux[15:0] = high_r;
    end else if (sel_sts) begin
      rd_mux[`LTIL_STS_W-1:0] = sts_r;
    end else if (sel_mask) begin
      rd_mux[`LTIL_STS_W-1:0] = mask_r;
    end else if (sel_res) begin
      rd_mux[15:0] = res_r;
    end
  end

  // Bus answer: waitrequest drops for one cycle after a taken access
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wreq_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wreq_r  <= !acc;
      rdata_r <= (acc && avs_read) ? rd_mux : rdata_r;
    end
  end

  // Register and state update
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_r  <= `LTIL_RST_CFG;
      low_r  <= `LTIL_RST_LOW;
      high_r <= `LTIL_RST_HIGH;
      res_r  <= 16'h0000;
      mask_r <= {`LTIL_STS_W{1'b0}};
      sts_r  <= {`LTIL_STS_W{1'b0}};
      {fh_r, fl_r, crdy_r, int_st_r} <= 4'h0;
    end else begin
      cfg_r  <= cfg_nxt;
      low_r  <= low_nxt;
      high_r <= high_nxt;
      res_r  <= conv.evt ? conv.result : res_r;
      mask_r <= mask_nxt;
      sts_r  <= sts_nxt;
      {fh_r, fl_r, crdy_r, int_st_r} <= {fh_nxt, fl_nxt, crdy_nxt, int_nxt};
    end
  end

  // Pin level and interrupt line, both registered
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      pin_r <= cfg_nxt[`LTIL_B_POL] ? int_nxt : !int_nxt;
      irq_r <= |(sts_nxt & mask_nxt);
    end
  end

  assign avs_waitrequest = wreq_r;
  assign avs_readdata    = rdata_r;
  assign int_pin         = pin_r;
  assign irq             = irq_r;

  property p_tr_high;
    @(posedge clk_sys) disable iff (!rstn)
    mode == ltil_pkg::mode_transp && hi_met |=> int_st_r && fh_r && !fl_r;
  endproperty
  a_tr_high: assert property (p_tr_high) else $error("high run not reported");

  property p_tr_low;
    @(posedge clk_sys) disable iff (!rstn)
    mode == ltil_pkg::mode_transp && lo_met && !hi_met |=> !int_st_r && fl_r && !fh_r;
  endproperty
  a_tr_low: assert property (p_tr_low) else $error("low run not reported");

  property p_tr_access;
    @(posedge clk_sys) disable iff (!rstn)
    mode == ltil_pkg::mode_transp && (rd_cfg || wr_cfg) && !conv.evt
      |=> $stable(int_st_r) && $stable(fh_r) && $stable(fl_r);
  endproperty
  a_tr_access: assert property (p_tr_access) else $error("config access moved flags");

  property p_tr_alert;
    @(posedge clk_sys) disable iff (!rstn)
    !cfg_r[`LTIL_B_LATCH] && alert_resp && !conv.evt && !rd_cfg && !wr_cfg
      |=> $stable(int_st_r) && $stable(fh_r) && $stable(fl_r);
  endproperty
  a_tr_alert: assert property (p_tr_alert) else $error("alert acted in transparent");

  property p_conv_ready;
    @(posedge clk_sys) disable iff (!rstn)
    conv.evt |=> crdy_r && sts_r[`LTIL_STS_CONV];
  endproperty
  a_conv_ready: assert property (p_conv_ready) else $error("ready not set");

  property p_shdn_write;
    @(posedge clk_sys) disable iff (!rstn)
    wr_cfg && !wr_run && !conv.evt |=> $stable(crdy_r) && $stable(fh_r) && $stable(fl_r);
  endproperty
  a_shdn_write: assert property (p_shdn_write) else $error("shutdown write moved flags");

  property p_run_write;
    @(posedge clk_sys) disable iff (!rstn)
    wr_run && !conv.evt |=> !crdy_r ##1 avs_waitrequest;
  endproperty
  a_run_write: assert property (p_run_write) else $error("run write kept ready");

  property p_eoc_conv;
    @(posedge clk_sys) disable iff (!rstn)
    eoc && conv.evt |=> int_st_r && crdy_r && int_pin == cfg_r[`LTIL_B_POL];
  endproperty
  a_eoc_conv: assert property (p_eoc_conv) else $error("eoc int missing");

  property p_eoc_clear;
    @(posedge clk_sys) disable iff (!rstn)
    eoc && (rd_cfg || wr_run) && !conv.evt |=> !int_st_r;
  endproperty
  a_eoc_clear: assert property (p_eoc_clear) else $error("eoc int not cleared");

  property p_eocl_flags;
    @(posedge clk_sys) disable iff (!rstn)
    mode == ltil_pkg::mode_eoc_l && hi_met |=> fh_r;
  endproperty
  a_eocl_flags: assert property (p_eocl_flags) else $error("eoc high flag missing");

  property p_pin_pol;
    @(posedge clk_sys) disable iff (!rstn)
    int_pin == (cfg_r[`LTIL_B_POL] ? int_st_r : !int_st_r);
  endproperty
  a_pin_pol: assert property (p_pin_pol) else $error("pin polarity wrong");

  property p_rd_ready;
    @(posedge clk_sys) disable iff (!rstn)
    rd_cfg && !conv.evt |=> !crdy_r && !avs_waitrequest;
  endproperty
  a_rd_ready: assert property (p_rd_ready) else $error("read kept ready");

  property p_eocl_read;
    @(posedge clk_sys) disable iff (!rstn)
    mode == ltil_pkg::mode_eoc_l && rd_cfg && !conv.evt |=> !fh_r && !fl_r && !crdy_r;
  endproperty
  a_eocl_read: assert property (p_eocl_read) else $error("eoc read kept flags");
endmodule

// file: tb/ltil_link_model.sv
module ltil_link_model (
  output logic        link_clk,    // Link clock, still between frames
  output logic        link_done,   // Conversion done qualifier
  output logic [15:0] link_result  // Measurement word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines at time zero
  initial begin
    link_clk    = 1'b0;
    link_done   = 1'b0;
    link_result = 16'h0000;
  end
  // One 320 ns frame carrying one measurement, odd offset keeps phase loose
  task automatic convert(input logic [15:0] v);
    #13 link_result = v;
    link_done = 1'b1;
    #57 link_clk = 1'b1;
    #160 link_clk = 1'b0;
    #40 link_done = 1'b0;
    link_result = ~v; // Released word no longer shows the last value
    #50;
  endtask
endmodule

// file: tb/ltil_tb_top.sv
module ltil_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys;         // System clock
  logic        rstn;            // Reset, active low
  logic [4:0]  avs_address;     // Register address
  logic        avs_read;        // Read request
  logic        avs_write;       // Write request
  logic [31:0] avs_writedata;   // Write data
  logic [31:0] avs_readdata;    // Read data
  logic        avs_waitrequest; // Answer strobe, low
  logic        link_clk;        // Link clock
  logic        link_done;       // Link qualifier
  logic [15:0] link_result;     // Link data
  logic        alert_resp;      // Alert response pulse
  logic        int_pin;         // Interrupt pin
  logic        irq;             // Software interrupt
  int          miscompares;     // Mismatch count
  int          checks_done;     // Comparison count

  ltil_top ltil_top_i (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_clk(link_clk), .link_done(link_done),
    .link_result(link_result), .alert_resp(alert_resp), .int_pin(int_pin), .irq(irq));
  ltil_link_model ltil_link_model_i (.link_clk(link_clk), .link_done(link_done),
    .link_result(link_result));

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  task automatic results();
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      $display("unexpected waitrequest: expected 0, seen %b", avs_waitrequest);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] junk;
    xfer(1'b1, a, d, junk);
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    chk(nm, e, v);
  endtask

  task automatic pin(input logic e);
    repeat (2) @(posedge clk_sys);
    chk_bit("int_pin", e, int_pin);
  endtask

  task automatic conv(input logic [15:0] v);
    ltil_link_model_i.convert(v);
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic alert();
    @(posedge clk_sys);
    alert_resp <= 1'b1;
    @(posedge clk_sys);
    alert_resp <= 1'b0;
  endtask

  task automatic t_reset();
    chk_bit("irq", 1'b0, irq);
    pin(1'b1);
    rd("cfg", 5'h00, 32'h0000_0010);
    rd("low", 5'h04, 32'h0000_0000);
    rd("high", 5'h08, 32'h0000_bfff);
    rd("mask", 5'h10, 32'h0000_0000);
  endtask

  task automatic t_transp();
    wr(5'h08, 32'h0000_1000);
    wr(5'h04, 32'h0000_0100);
    wr(5'h00, 32'h0000_0201);
    conv(16'h2000);
    rd("cfg", 5'h00, 32'h0000_0281);
    rd("cfg", 5'h00, 32'h0000_0201);
    conv(16'h0500);
    conv(16'h2000);
    pin(1'b1);
    conv(16'h2000);
    pin(1'b0);
    rd("cfg", 5'h00, 32'h0000_02c1);
    pin(1'b0);
    conv(16'h2000);
    wr(5'h00, 32'h0000_0201);
    pin(1'b0);
    rd("cfg", 5'h00, 32'h0000_0241);
    alert();
    pin(1'b0);
    conv(16'h0010);
    pin(1'b0);
    conv(16'h0010);
    pin(1'b1);
    rd("cfg", 5'h00, 32'h0000_02a1);
    wr(5'h00, 32'h0000_0209);
    pin(1'b0);
  endtask

  task automatic t_shutdown();
    conv(16'h0010);
    wr(5'h00, 32'h0000_0009);
    rd("cfg", 5'h00, 32'h0000_00a9);
    pin(1'b0);
  endtask

  task automatic t_irq();
    wr(5'h00, 32'h0000_0201);
    wr(5'h10, 32'h0000_0001);
    rd("status", 5'h0c, 32'h0000_0007);
    chk_bit("irq", 1'b0, irq);
    conv(16'h0500);
    chk_bit("irq", 1'b1, irq);
    rd("status", 5'h0c, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk_bit("irq", 1'b0, irq);
    wr(5'h10, 32'h0000_0000);
    conv(16'h0500);
    chk_bit("irq", 1'b0, irq);
    rd("status", 5'h0c, 32'h0000_0001);
    wr(5'h18, 32'h0000_ffff);
    rd("unmapped", 5'h18, 32'h0000_0000);
  endtask

  task automatic t_eoc();
    wr(5'h08, 32'h0000_d000);
    wr(5'h04, 32'h0000_c100);
    wr(5'h00, 32'h0000_0211);
    pin(1'b1);
    conv(16'h2000);
    pin(1'b0);
    rd("cfg", 5'h00, 32'h0000_02b1);
    pin(1'b1);
    rd("cfg", 5'h00, 32'h0000_0211);
    conv(16'he000);
    pin(1'b0);
    conv(16'he000);
    pin(1'b0);
    alert();
    pin(1'b1);
    rd("cfg", 5'h00, 32'h0000_02d1);
    conv(16'hc800);
    pin(1'b0);
    wr(5'h00, 32'h0000_0211);
    pin(1'b1);
  endtask

  task automatic t_leave_eoc();
    conv(16'hc800);
    pin(1'b0);
    rd("result", 5'h14, 32'h0000_c800);
    wr(5'h04, 32'h0000_0100);
    wr(5'h00, 32'h0000_0201);
    pin(1'b1);
    wr(5'h00, 32'h0000_0211);
    pin(1'b1);
  endtask

  // Main sequence
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    alert_resp = 1'b0;
    miscompares = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_transp();
    t_shutdown();
    t_irq();
    t_eoc();
    t_leave_eoc();
    results();
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule
